// ===== src/ddr2_channel_timing_config.sv
// Channel timing and bank-geometry registers with the command spacing gate they steer.
// Operation
// - Per-rank two-bit code selects four or eight banks.
// - Write to precharge spacing, four to fifteen clocks.
// - Write to read same rank, six to twelve.
// - Write-read different rank: code 00 six, 01 five.
// - Write-write different rank turnaround, code 10 gives four.
// - Read-read different rank: zero six, one five.
// - Chip select to host data ready, three-seven clocks.
// - Write auto-precharge to activate, four to twenty-one.
// - Read auto-precharge to activate, three to twelve.
// - Read to precharge: half burst, or plus one.
// - Activate to precharge, four to eighteen clocks.
// - Precharge to precharge other bank: one or two.
// - Precharge-all to activate adds a clock when set.
// - Refresh to activate spacing, reset value 1Ch.
// - CAS latency select, reset code gives four clocks.
// - Activate to read/write: two to six clocks.
// - Precharge to activate: two to seven clocks.
`timescale 1ns/100ps
`include "ddr2_timing_defs.svh"
module ddr2_channel_timing_config
  import ddr2_timing_pkg::*;
#(
  parameter int NUM_RANKS = 4
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_reg_wr_en,
  input  wire logic        i_reg_rd_en,
  input  wire logic [11:0] i_reg_addr,
  input  wire logic [3:0]  i_reg_byte_en,
  input  wire logic [31:0] i_reg_wdata,
  output logic      [31:0] o_reg_rdata,
  output logic             o_reg_rd_valid,
  input  wire logic        i_cmd_valid,
  input  wire dram_cmd_e   i_cmd_type,
  input  wire logic [1:0]  i_cmd_rank,
  input  wire logic [2:0]  i_cmd_bank,
  output logic             o_cmd_ready,
  output logic      [2:0]  o_cas_latency,
  output logic      [2:0]  o_read_delay_clocks,
  output logic             o_cfg_reserved
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [31:0] rdata;
    logic        rd_valid;
    logic [7:0]  geom;
    logic [31:0] prim;
    logic [31:0] sec;
    logic [2:0]  cas;
    logic [2:0]  rdly;
    logic        rsv;
  } cfg_state_s;

  cfg_state_s state_reg;
  cfg_state_s state_next;

  timing_if cfg_timing ();

  logic       sel_geom;
  logic       sel_prim;
  logic       sel_sec;
  logic       geom_rsv;
  logic       issue;
  logic       idle     [NUM_RANKS][NUM_KINDS];
  logic       load_en  [NUM_RANKS][NUM_KINDS];
  clk_count_t load_val [NUM_RANKS][NUM_KINDS];

  // Merges written bytes into a register, keeping read-only bits unchanged.
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] wd,
                                        logic [3:0] be, logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = (wd[8*b +: 8] & mask[8*b +: 8]) | (old[8*b +: 8] & ~mask[8*b +: 8]);
      end
    end
    merge = res;
  endfunction : merge

  // ****************************************************************
  // Field decoding
  // ****************************************************************
  timing_field_decode u_decode (
    .i_primary   (state_reg.prim),
    .i_secondary (state_reg.sec),
    .o_timing    (cfg_timing.src)
  );

  // Word decode: the geometry register sits in the upper half of its word.
  assign sel_geom = (i_reg_addr[11:`WORD_SHIFT] ==
                     10'(`ADDR_RANK_BANK_GEOMETRY >> `WORD_SHIFT));
  assign sel_prim = (i_reg_addr[11:`WORD_SHIFT] ==
                     10'(`ADDR_CHANNEL_TIMING_PRIMARY >> `WORD_SHIFT));
  assign sel_sec  = (i_reg_addr[11:`WORD_SHIFT] ==
                     10'(`ADDR_CHANNEL_TIMING_SECONDARY >> `WORD_SHIFT));

  // Reserved geometry codes, or eight-bank ranks without the longer precharge-all.
  always_comb begin
    geom_rsv = 1'b0;
    for (int r = 0; r < NUM_RANKS; r++) begin
      if (state_reg.geom[2*r+1]) begin
        geom_rsv = 1'b1;
      end
      if (state_reg.geom[2*r] && !state_reg.sec[`S_RPALL]) begin
        geom_rsv = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  // Writes merge by byte lane, reads return one cycle later, unmapped words read zero.
  always_comb begin
    logic [31:0] geom_word;
    geom_word  = '0;
    state_next = state_reg;
    geom_word  = {16'h0000, state_reg.geom, 8'h00} << 8;
    if (i_reg_wr_en && sel_geom && i_reg_byte_en[`GEOM_LANE_LO]) begin
      state_next.geom = i_reg_wdata[8*`GEOM_LANE_LO +: 8];
    end
    if (i_reg_wr_en && sel_prim) begin
      state_next.prim = merge(state_reg.prim, i_reg_wdata, i_reg_byte_en, `MASK_PRIMARY);
    end
    if (i_reg_wr_en && sel_sec) begin
      state_next.sec = merge(state_reg.sec, i_reg_wdata, i_reg_byte_en, `MASK_SECONDARY);
    end
    state_next.rd_valid = i_reg_rd_en;
    if (i_reg_rd_en) begin
      state_next.rdata = sel_geom ? geom_word :
                         sel_prim ? state_reg.prim :
                         sel_sec  ? state_reg.sec : 32'h0000_0000;
    end
    state_next.cas  = cfg_timing.cas_lat;
    state_next.rdly = cfg_timing.read_delay;
    state_next.rsv  = cfg_timing.reserved | geom_rsv;
  end

  // State register.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg.rdata    <= 32'h0000_0000;
      state_reg.rd_valid <= 1'b0;
      state_reg.geom     <= `RST_GEOMETRY;
      state_reg.prim     <= `RST_PRIMARY;
      state_reg.sec      <= `RST_SECONDARY;
      state_reg.cas      <= `CL_01;
      state_reg.rdly     <= 3'(`RDLY_MAX);
      state_reg.rsv      <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_reg_rdata         = state_reg.rdata;
  assign o_reg_rd_valid      = state_reg.rd_valid;
  assign o_cas_latency       = state_reg.cas;
  assign o_read_delay_clocks = state_reg.rdly;
  assign o_cfg_reserved      = state_reg.rsv;

  // ****************************************************************
  // Command spacing gate
  // ****************************************************************
  // A command passes only when its class is free on its rank and, for all but PREALL and REF, its bank exists.
  always_comb begin
    logic eight;
    logic bank_ok;
    logic r_act;
    logic r_pre;
    logic r_rd;
    logic r_wr;
    eight   = state_reg.geom[2*i_cmd_rank];
    bank_ok = !state_reg.geom[2*i_cmd_rank+1] && (eight || !i_cmd_bank[2]);
    r_act   = idle[i_cmd_rank][KIND_ACT];
    r_pre   = idle[i_cmd_rank][KIND_PRE];
    r_rd    = idle[i_cmd_rank][KIND_RD];
    r_wr    = idle[i_cmd_rank][KIND_WR];
    case (i_cmd_type)
      CMD_ACT:            o_cmd_ready = bank_ok && r_act;
      CMD_RD, CMD_RDA:    o_cmd_ready = bank_ok && r_rd;
      CMD_WR, CMD_WRA:    o_cmd_ready = bank_ok && r_wr;
      CMD_PRE:            o_cmd_ready = bank_ok && r_pre;
      CMD_PREALL:         o_cmd_ready = !state_reg.geom[2*i_cmd_rank+1] && r_pre;
      CMD_REF:            o_cmd_ready = !state_reg.geom[2*i_cmd_rank+1] && r_act && r_pre;
      default:            o_cmd_ready = 1'b0;
    endcase
  end

  assign issue = i_cmd_valid && o_cmd_ready;

  // Each issued command loads the spacings it imposes on later commands.
  always_comb begin
    logic same;
    same = 1'b0;
    for (int r = 0; r < NUM_RANKS; r++) begin
      same = (r[1:0] == i_cmd_rank);
      for (int k = 0; k < NUM_KINDS; k++) begin
        load_en[r][k]  = 1'b0;
        load_val[r][k] = '0;
      end
      if (issue) begin
        case (i_cmd_type)
          CMD_ACT: begin
            if (same) begin
              load_en[r][KIND_RD]  = 1'b1;
              load_val[r][KIND_RD] = cfg_timing.rcd;
              load_en[r][KIND_WR]  = 1'b1;
              load_val[r][KIND_WR] = cfg_timing.rcd;
              load_en[r][KIND_PRE]  = 1'b1;
              load_val[r][KIND_PRE] = cfg_timing.ras;
            end
          end
          CMD_RD, CMD_RDA: begin
            if (same) begin
              load_en[r][KIND_PRE]  = 1'b1;
              load_val[r][KIND_PRE] = cfg_timing.rd_to_pre;
              load_en[r][KIND_ACT]  = (i_cmd_type == CMD_RDA);
              load_val[r][KIND_ACT] = cfg_timing.rd_ap_act;
            end else begin
              load_en[r][KIND_RD]  = 1'b1;
              load_val[r][KIND_RD] = cfg_timing.rd_rd_diff;
            end
          end
          CMD_WR, CMD_WRA: begin
            if (same) begin
              load_en[r][KIND_PRE]  = 1'b1;
              load_val[r][KIND_PRE] = cfg_timing.wr_to_pre;
              load_en[r][KIND_RD]   = 1'b1;
              load_val[r][KIND_RD]  = cfg_timing.wr_to_rd;
              load_en[r][KIND_ACT]  = (i_cmd_type == CMD_WRA);
              load_val[r][KIND_ACT] = cfg_timing.wr_ap_act;
            end else begin
              load_en[r][KIND_RD]  = 1'b1;
              load_val[r][KIND_RD] = cfg_timing.wr_rd_diff;
              load_en[r][KIND_WR]  = 1'b1;
              load_val[r][KIND_WR] = cfg_timing.wr_wr_diff;
            end
          end
          CMD_PRE: begin
            if (same) begin
              load_en[r][KIND_ACT]  = 1'b1;
              load_val[r][KIND_ACT] = cfg_timing.rp;
              load_en[r][KIND_PRE]  = 1'b1;
              load_val[r][KIND_PRE] = cfg_timing.pre_pre;
            end
          end
          CMD_PREALL: begin
            if (same) begin
              load_en[r][KIND_ACT]  = 1'b1;
              load_val[r][KIND_ACT] = cfg_timing.rp_all;
            end
          end
          CMD_REF: begin
            if (same) begin
              load_en[r][KIND_ACT]  = 1'b1;
              load_val[r][KIND_ACT] = cfg_timing.rfc;
            end
          end
          default: begin
            load_en[r][KIND_ACT] = 1'b0;
          end
        endcase
      end
    end
  end

  // One spacing timer per rank and command class.
  for (genvar gr = 0; gr < NUM_RANKS; gr++) begin : g_rank
    for (genvar gk = 0; gk < NUM_KINDS; gk++) begin : g_kind
      spacing_timer #(
        .W ($bits(clk_count_t))
      ) u_timer (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_load     (load_en[gr][gk]),
        .i_value    (load_val[gr][gk]),
        .o_idle     (idle[gr][gk])
      );
    end
  end
endmodule : ddr2_channel_timing_config

// ===== src/ddr2_timing_defs.svh
// Offsets, field positions, reset values and timing figures of the channel timing block.
`ifndef DDR2_TIMING_DEFS_SVH
`define DDR2_TIMING_DEFS_SVH

// ****************************************************************
// Register byte offsets inside the controller window
// ****************************************************************
`define ADDR_RANK_BANK_GEOMETRY       12'h10e
`define ADDR_CHANNEL_TIMING_PRIMARY   12'h110
`define ADDR_CHANNEL_TIMING_SECONDARY 12'h114
`define WORD_SHIFT                    2
`define GEOM_LANE_LO                  2
`define GEOM_LANE_HI                  3

// ****************************************************************
// Reset values and writable-bit masks
// ****************************************************************
`define RST_GEOMETRY   8'h00
`define RST_PRIMARY    32'hb96038f8
`define RST_SECONDARY  32'h02607122
`define MASK_PRIMARY   32'hfffdf9ff
`define MASK_SECONDARY 32'hffffff77

// ****************************************************************
// Primary timing fields
// ****************************************************************
`define P_WRPRE_HI 31
`define P_WRPRE_LO 28
`define P_WRRD_HI  27
`define P_WRRD_LO  24
`define P_WRRDX_HI 23
`define P_WRRDX_LO 22
`define P_WRWRX_HI 19
`define P_WRWRX_LO 18
`define P_RDRDX    16
`define P_RDLY_HI  15
`define P_RDLY_LO  11
`define P_WRAP_HI  8
`define P_WRAP_LO  4
`define P_RDAP_HI  3
`define P_RDAP_LO  0

// ****************************************************************
// Secondary timing fields
// ****************************************************************
`define S_RTP_HI   29
`define S_RTP_LO   28
`define S_RAS_HI   23
`define S_RAS_LO   19
`define S_PREPRE   18
`define S_RPALL    16
`define S_RFC_HI   15
`define S_RFC_LO   10
`define S_CL_HI    9
`define S_CL_LO    8
`define S_RCD_HI   6
`define S_RCD_LO   4
`define S_RP_HI    2
`define S_RP_LO    0

// ****************************************************************
// Spacing figures in DRAM clocks
// ****************************************************************
`define WRPRE_MIN   6'd4
`define WRRD_MIN    6'd6
`define WRRD_MAX    6'd12
`define WRAP_MIN    6'd4
`define WRAP_MAX    6'd21
`define RDAP_MIN    6'd3
`define RDAP_MAX    6'd12
`define RAS_MIN     6'd4
`define RAS_MAX     6'd18
`define WRRD_DR_00  6'd6
`define WRRD_DR_01  6'd5
`define WRRD_DR_10  6'd4
`define WRWR_DR_00  6'd6
`define WRWR_DR_01  6'd5
`define WRWR_DR_10  6'd4
`define RDRD_DR_0   6'd6
`define RDRD_DR_1   6'd5
`define RTP_00      6'd4
`define RTP_01      6'd5
`define PREPRE_0    6'd1
`define PREPRE_1    6'd2
`define RPALL_EXTRA 6'd1
`define RCD_RP_BASE 6'd2
`define RCD_MAX_CODE 3'd4
`define RP_MAX_CODE  3'd5
`define CL_00       3'd5
`define CL_01       3'd4
`define CL_10       3'd3
`define CL_11       3'd6
`define RDLY_MIN    5'd3
`define RDLY_MAX    5'd7

`endif

// ===== src/ddr2_timing_pkg.sv
// Types shared by the channel timing block.
package ddr2_timing_pkg;
  typedef logic [5:0] clk_count_t;
  typedef enum logic [2:0] {
    CMD_ACT    = 3'h0,
    CMD_RD     = 3'h1,
    CMD_RDA    = 3'h2,
    CMD_WR     = 3'h3,
    CMD_WRA    = 3'h4,
    CMD_PRE    = 3'h5,
    CMD_PREALL = 3'h6,
    CMD_REF    = 3'h7
  } dram_cmd_e;
  localparam int KIND_ACT  = 0;
  localparam int KIND_PRE  = 1;
  localparam int KIND_RD   = 2;
  localparam int KIND_WR   = 3;
  localparam int NUM_KINDS = 4;
endpackage : ddr2_timing_pkg

// ===== src/spacing_timer.sv
// Countdown that holds off one command class until its spacing has elapsed.
`timescale 1ns/100ps
`include "ddr2_timing_defs.svh"
module spacing_timer
  import ddr2_timing_pkg::*;
#(
  parameter int W = 6
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_value,
  output logic              o_idle
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } timer_state_s;

  timer_state_s state_reg;
  timer_state_s state_next;

  // A load of N clocks leaves N-1 to count, so the class frees N edges later.
  // A shorter load never cuts an older, longer spacing.
  always_comb begin
    logic [W-1:0] dec;
    logic [W-1:0] want;
    dec        = '0;
    want       = '0;
    state_next = state_reg;
    dec        = (state_reg.cnt == '0) ? '0 : state_reg.cnt - 1'b1;
    want       = (i_value == '0) ? '0 : i_value - 1'b1;
    state_next.cnt = (i_load && (want > dec)) ? want : dec;
  end

  // State register.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_idle = (state_reg.cnt == '0);
endmodule : spacing_timer

// ===== src/timing_field_decode.sv
// Turns the programmed timing fields into spacing counts in DRAM clocks.
`timescale 1ns/100ps
`include "ddr2_timing_defs.svh"
module timing_field_decode
  import ddr2_timing_pkg::*;
(
  input  wire logic [31:0] i_primary,
  input  wire logic [31:0] i_secondary,
  timing_if.src            o_timing
);
  // Raises a spacing to its least legal figure; longer codes are kept as they are.
  function automatic clk_count_t at_least(clk_count_t v, clk_count_t m);
    at_least = (v < m) ? m : v;
  endfunction : at_least

  logic [1:0] wrrdx_code;
  logic [1:0] wrwrx_code;
  logic [4:0] rdly_code;
  logic [1:0] rtp_code;
  logic [2:0] rcd_code;
  logic [2:0] rp_code;
  clk_count_t wrpre_raw;
  clk_count_t wrrd_raw;
  clk_count_t wrap_raw;
  clk_count_t rdap_raw;
  clk_count_t ras_raw;

  assign wrrdx_code = i_primary[`P_WRRDX_HI:`P_WRRDX_LO];
  assign wrwrx_code = i_primary[`P_WRWRX_HI:`P_WRWRX_LO];
  assign rdly_code  = i_primary[`P_RDLY_HI:`P_RDLY_LO];
  assign rtp_code   = i_secondary[`S_RTP_HI:`S_RTP_LO];
  assign rcd_code   = i_secondary[`S_RCD_HI:`S_RCD_LO];
  assign rp_code    = i_secondary[`S_RP_HI:`S_RP_LO];
  assign wrpre_raw  = {2'b00, i_primary[`P_WRPRE_HI:`P_WRPRE_LO]};
  assign wrrd_raw   = {2'b00, i_primary[`P_WRRD_HI:`P_WRRD_LO]};
  assign wrap_raw   = {1'b0, i_primary[`P_WRAP_HI:`P_WRAP_LO]};
  assign rdap_raw   = {2'b00, i_primary[`P_RDAP_HI:`P_RDAP_LO]};
  assign ras_raw    = {1'b0, i_secondary[`S_RAS_HI:`S_RAS_LO]};

  // Same-bank and same-rank spacings, low reserved codes raised to the least legal value.
  assign o_timing.wr_to_pre = at_least(wrpre_raw, `WRPRE_MIN);
  assign o_timing.wr_to_rd  = at_least(wrrd_raw, `WRRD_MIN);
  assign o_timing.wr_ap_act = at_least(wrap_raw, `WRAP_MIN);
  assign o_timing.rd_ap_act = at_least(rdap_raw, `RDAP_MIN);
  assign o_timing.ras       = at_least(ras_raw, `RAS_MIN);
  assign o_timing.rfc       = i_secondary[`S_RFC_HI:`S_RFC_LO];

  // Encoded spacings; reserved codes fall back to the longest figure.
  always_comb begin
    case (wrrdx_code)
      2'b01:   o_timing.wr_rd_diff = `WRRD_DR_01;
      2'b10:   o_timing.wr_rd_diff = `WRRD_DR_10;
      default: o_timing.wr_rd_diff = `WRRD_DR_00;
    endcase
    case (wrwrx_code)
      2'b01:   o_timing.wr_wr_diff = `WRWR_DR_01;
      2'b10:   o_timing.wr_wr_diff = `WRWR_DR_10;
      default: o_timing.wr_wr_diff = `WRWR_DR_00;
    endcase
    case (rtp_code)
      2'b00:   o_timing.rd_to_pre = `RTP_00;
      default: o_timing.rd_to_pre = `RTP_01;
    endcase
    case (i_secondary[`S_CL_HI:`S_CL_LO])
      2'b00:   o_timing.cas_lat = `CL_00;
      2'b01:   o_timing.cas_lat = `CL_01;
      2'b10:   o_timing.cas_lat = `CL_10;
      default: o_timing.cas_lat = `CL_11;
    endcase
  end

  // Single-bit choices and offset codes.
  assign o_timing.rd_rd_diff = i_primary[`P_RDRDX] ? `RDRD_DR_1 : `RDRD_DR_0;
  assign o_timing.pre_pre = i_secondary[`S_PREPRE] ? `PREPRE_1 : `PREPRE_0;
  assign o_timing.rcd = {3'b000, rcd_code} + `RCD_RP_BASE;
  assign o_timing.rp  = {3'b000, rp_code} + `RCD_RP_BASE;
  assign o_timing.rp_all = o_timing.rp + (i_secondary[`S_RPALL] ? `RPALL_EXTRA : 6'd0);

  // Read delay is clamped into its legal window of three to seven clocks.
  assign o_timing.read_delay = (rdly_code < `RDLY_MIN) ? 3'(`RDLY_MIN) :
                               (rdly_code > `RDLY_MAX) ? 3'(`RDLY_MAX) :
                               rdly_code[2:0];

  // Any reserved code in either timing register.
  assign o_timing.reserved = (wrpre_raw < `WRPRE_MIN) || (wrrd_raw < `WRRD_MIN) ||
                             (wrrd_raw > `WRRD_MAX) || (wrrdx_code == 2'b11) ||
                             (wrwrx_code == 2'b11) || (rdly_code < `RDLY_MIN) ||
                             (rdly_code > `RDLY_MAX) || (wrap_raw < `WRAP_MIN) ||
                             (wrap_raw > `WRAP_MAX) || (rdap_raw < `RDAP_MIN) ||
                             (rdap_raw > `RDAP_MAX) || rtp_code[1] ||
                             (ras_raw < `RAS_MIN) || (ras_raw > `RAS_MAX) ||
                             (rcd_code > `RCD_MAX_CODE) || (rp_code > `RP_MAX_CODE);
endmodule : timing_field_decode

// ===== src/timing_if.sv
// Decoded spacing values passed from the field decoder to the scheduler gate.
`timescale 1ns/100ps
interface timing_if;
  import ddr2_timing_pkg::*;
  clk_count_t wr_to_pre;
  clk_count_t wr_to_rd;
  clk_count_t wr_rd_diff;
  clk_count_t wr_wr_diff;
  clk_count_t rd_rd_diff;
  clk_count_t wr_ap_act;
  clk_count_t rd_ap_act;
  clk_count_t rd_to_pre;
  clk_count_t ras;
  clk_count_t pre_pre;
  clk_count_t rp;
  clk_count_t rp_all;
  clk_count_t rfc;
  clk_count_t rcd;
  logic [2:0] cas_lat;
  logic [2:0] read_delay;
  logic       reserved;
  modport src (output wr_to_pre, wr_to_rd, wr_rd_diff, wr_wr_diff, rd_rd_diff, wr_ap_act,
               rd_ap_act, rd_to_pre, ras, pre_pre, rp, rp_all, rfc, rcd, cas_lat,
               read_delay, reserved);
  modport dst (input wr_to_pre, wr_to_rd, wr_rd_diff, wr_wr_diff, rd_rd_diff, wr_ap_act,
               rd_ap_act, rd_to_pre, ras, pre_pre, rp, rp_all, rfc, rcd, cas_lat,
               read_delay, reserved);
endinterface : timing_if

// ===== testbench/ddr2_channel_timing_config_test.sv
// Self-checking bench for the channel timing block.
`timescale 1ns/100ps
module ddr2_channel_timing_config_test;
  import ddr2_timing_pkg::*;
  // **********
  // Stimulus
  // **********
  logic        clk = 0, rst = 1, we = 0, re = 0, cv = 0, rv, rdy, rsv;
  logic [11:0] addr = 0;
  logic [3:0]  be = 0;
  logic [31:0] wd = 0, rdat;
  dram_cmd_e   ct = CMD_ACT;
  logic [1:0]  cr = 0;
  logic [2:0]  cb = 0, cas, rdly;
  logic [2:0]  cl [4] = '{3'h5, 3'h4, 3'h3, 3'h6};
  int          n_fail = 0, comparisons = 0, cyc = 0, n_iss = 0, cnt;
  // Rows: leader, follower, follower rank, expected spacing.
  logic [19:0] gt [14] = '{20'h01004, 20'h0500c, 20'h50004, 20'h60004, 20'h7001c, 20'h3500b,
    20'h31009, 20'h4000f, 20'h20008, 20'h15004, 20'h11106, 20'h31105, 20'h33106, 20'h55001};
  // The clock toggles every half period.
  always #20 clk = ~clk;
  ddr2_channel_timing_config uut (.i_core_clk(clk), .i_sys_rst(rst), .i_reg_wr_en(we),
    .i_reg_rd_en(re), .i_reg_addr(addr), .i_reg_byte_en(be), .i_reg_wdata(wd),
    .o_reg_rdata(rdat), .o_reg_rd_valid(rv), .i_cmd_valid(cv), .i_cmd_type(ct),
    .i_cmd_rank(cr), .i_cmd_bank(cb), .o_cmd_ready(rdy), .o_cas_latency(cas),
    .o_read_delay_clocks(rdly), .o_cfg_reserved(rsv));
  dram_partner far (.i_core_clk(clk), .i_sys_rst(rst), .i_issue(cv && rdy), .o_count(cnt));
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  // One register write, then time for the decoded outputs to follow.
  task automatic wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk) {we, addr, be, wd} <= {1'b1, a, b, d};
    @(posedge clk) we <= 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : wr
  // One register read compared in its valid cycle.
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk) {re, addr} <= {1'b1, a};
    @(posedge clk) re <= 0;
    @(negedge clk) chk(e, rdat);
    chk(1'b1, rv);
  endtask : rd
  // Offers one command and checks whether it is taken.
  task automatic offer(input dram_cmd_e t, input logic [2:0] b, input logic e);
    @(posedge clk) cv <= 1;
    ct <= t;
    cr <= 0;
    cb <= b;
    @(negedge clk) chk(e, rdy);
    n_iss += e;
    @(posedge clk) cv <= 0;
    repeat (32) @(posedge clk);
  endtask : offer
  // Issues a leader, then counts clocks until the follower is taken.
  task automatic gap(input logic [19:0] g);
    int n;
    @(posedge clk) cv <= 1;
    ct <= dram_cmd_e'(g[18:16]);
    cr <= 0;
    cb <= 0;
    @(posedge clk) ct <= dram_cmd_e'(g[14:12]);
    cr <= g[9:8];
    n = 1;
    @(negedge clk);
    while (rdy !== 1'b1 && n < 64) begin
      @(negedge clk) n++;
    end
    @(posedge clk) cv <= 0;
    chk(g[7:0], n);
    n_iss += 2;
    repeat (32) @(posedge clk);
  endtask : gap
  // Prints the counts and the verdict, then stops.
  task automatic test_done;
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // Cuts a hung run short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      test_done;
    end
  end
  // Main sequence.
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    rd(12'h110, 32'hb96038f8);
    rd(12'h114, 32'h02607122);
    rd(12'h10c, 32'h0);
    chk(3'h4, cas);
    wr(12'h110, 4'hf, 32'hffffffff);
    rd(12'h110, 32'hfffdf9ff);
    chk(3'h7, rdly);
    chk(1'b1, rsv);
    wr(12'h118, 4'hf, 32'hffffffff);
    rd(12'h118, 32'h0);
    for (int d = 3; d < 8; d++) begin
      wr(12'h110, 4'hf, 32'hb96000f8 | (d << 11));
      chk(d[2:0], rdly);
    end
    for (int c = 0; c < 4; c++) begin
      wr(12'h114, 4'hf, 32'h02607022 | (c << 8));
      chk(cl[c], cas);
    end
    wr(12'h114, 4'hf, 32'h02607122);
    chk(1'b0, rsv);
    $display("test registers done");
    for (int i = 0; i < 14; i++) gap(gt[i]);
    wr(12'h114, 4'hf, 32'h02657122);
    gap(20'h60005);
    gap(20'h55002);
    $display("test spacing done");
    offer(CMD_ACT, 3'h4, 1'b0);
    wr(12'h10c, 4'h4, 32'h00010000);
    offer(CMD_ACT, 3'h4, 1'b1);
    wr(12'h114, 4'hf, 32'h02607122);
    chk(1'b1, rsv);
    wr(12'h10c, 4'h4, 32'h00020000);
    offer(CMD_ACT, 3'h0, 1'b0);
    rd(12'h10c, 32'h00020000);
    chk(n_iss, cnt);
    $display("test geometry done");
    test_done;
  end
endmodule : ddr2_channel_timing_config_test

// ===== testbench/ddr2_timing_checker_properties.sv
// Port-level checks for the channel timing block.
`timescale 1ns/100ps
module ddr2_timing_checker
  import ddr2_timing_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_reg_wr_en,
  input wire logic        i_reg_rd_en,
  input wire logic [11:0] i_reg_addr,
  input wire logic [3:0]  i_reg_byte_en,
  input wire logic [31:0] i_reg_wdata,
  input wire logic [31:0] o_reg_rdata,
  input wire logic        i_cmd_valid,
  input wire dram_cmd_e   i_cmd_type,
  input wire logic [1:0]  i_cmd_rank,
  input wire logic        o_cmd_ready,
  input wire logic [2:0]  o_cas_latency,
  input wire logic [2:0]  o_read_delay_clocks
);
  // **********
  // Checks
  // **********
  default clocking dc @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // Issue strobe and word address shared by the checks.
  wire       iss = i_cmd_valid && o_cmd_ready;
  wire [9:0] w   = i_reg_addr[11:2];
  // Latency code to clocks.
  function automatic logic [2:0] cl(input logic [1:0] c);
    return c == 2'h0 ? 3'h5 : c == 2'h1 ? 3'h4 : c == 2'h2 ? 3'h3 : 3'h6;
  endfunction : cl
  // For the checked pairs (ACT-RD, PRE-ACT, WR-RD), a same-rank follower is never legal one clock after its leader.
  property p_hold(dram_cmd_e a, dram_cmd_e b);
    iss && i_cmd_type == a ##1 i_cmd_valid && i_cmd_type == b &&
      i_cmd_rank == $past(i_cmd_rank) |-> !o_cmd_ready;
  endproperty
  a_geom_ro_zero: assert property (i_reg_rd_en && w == 10'h043 |=>
    o_reg_rdata[15:0] == 16'h0 && o_reg_rdata[31:24] == 8'h0) else $error("geometry RO bits");
  a_prim_ro_zero: assert property (i_reg_rd_en && w == 10'h044 |=>
    !o_reg_rdata[17] && o_reg_rdata[10:9] == 2'h0) else $error("primary RO bits");
  a_sec_ro_zero: assert property (i_reg_rd_en && w == 10'h045 |=>
    !o_reg_rdata[7] && !o_reg_rdata[3]) else $error("secondary RO bits");
  a_cas_decode: assert property (i_reg_wr_en && w == 10'h045 && i_reg_byte_en[1]
    ##1 !i_reg_wr_en |=> o_cas_latency == cl($past(i_reg_wdata[9:8], 2)))
    else $error("cas latency decode");
  a_rdly_decode: assert property (i_reg_wr_en && w == 10'h044 && i_reg_byte_en[1] &&
    i_reg_wdata[15:11] inside {[5'h3:5'h7]} ##1 !i_reg_wr_en
    |=> o_read_delay_clocks == $past(i_reg_wdata[13:11], 2)) else $error("read delay decode");
  a_act_rd_hold: assert property (p_hold(CMD_ACT, CMD_RD)) else $error("act to rd");
  a_pre_act_hold: assert property (p_hold(CMD_PRE, CMD_ACT)) else $error("pre to act");
  a_wr_rd_hold: assert property (p_hold(CMD_WR, CMD_RD)) else $error("wr to rd");
  // Main scenarios reached.
  c_refresh: cover property (iss && i_cmd_type == CMD_REF);
  c_pre_all: cover property (iss && i_cmd_type == CMD_PREALL);
  c_refused: cover property (i_cmd_valid && !o_cmd_ready);
endmodule : ddr2_timing_checker
bind ddr2_channel_timing_config ddr2_timing_checker chk (.i_core_clk, .i_sys_rst,
  .i_reg_wr_en, .i_reg_rd_en, .i_reg_addr, .i_reg_byte_en, .i_reg_wdata, .o_reg_rdata,
  .i_cmd_valid, .i_cmd_type, .i_cmd_rank, .o_cmd_ready, .o_cas_latency, .o_read_delay_clocks);

// ===== testbench/dram_partner.sv
// Far-side model: the DRAM ranks, counting commands that reach them.
`timescale 1ns/100ps
module dram_partner (
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_issue,
  output int        o_count
);
  // Every issued command lands on the channel once.
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) o_count <= 0;
    else if (i_issue) o_count <= o_count + 1;
  end
endmodule : dram_partner
